// file: design/pmi_pkg.sv
// shared constants, register map and types for the power-management i2c target
package pmi_pkg;
   localparam int DATA_W = 8;
   localparam int PTR_W = 7;
   localparam int IDX_W = 6;
   localparam int MEM_DEPTH = 64;
   localparam int NGRP = 3;

   // clock and bus timing
   localparam int CLK_HZ = 50_000_000;
   localparam int FMP_BIT_HZ = 1_000_000;
   localparam int T_VD_NS = 450;
   localparam int VD_CYC = (T_VD_NS * (CLK_HZ / 1_000_000)) / 1000;

   // register addresses
   localparam logic [PTR_W-1:0] A_DEVICE_INFORMATION = 7'h00;
   localparam logic [PTR_W-1:0] A_TOP_SUM = 7'h01;
   localparam logic [PTR_W-1:0] A_CTRL_E = 7'h0D;
   localparam logic [PTR_W-1:0] A_CHG_STATE_A = 7'h18;
   localparam logic [PTR_W-1:0] A_REG_STATE = 7'h20;
   localparam logic [PTR_W-1:0] A_MODE_LAST = 7'h31;
   localparam logic [PTR_W-1:0] A_LAST = 7'h71;
   localparam logic [PTR_W-1:0] A_FIRST = 7'h00;
   localparam logic [PTR_W-1:0] A_FLAG [NGRP] = '{7'h02, 7'h04, 7'h06};
   localparam logic [PTR_W-1:0] A_MASK [NGRP] = '{7'h03, 7'h05, 7'h07};
   localparam logic [IDX_W-1:0] RESTART_IDX = 6'h3F;

   // reset values and field layout
   localparam logic [DATA_W-1:0] MASK_RST [NGRP] = '{8'h3F, 8'h7F, 8'hFF};
   localparam logic [DATA_W-1:0] FLAG_IMPL [NGRP] = '{8'h3F, 8'hFF, 8'hFF};
   localparam logic [DATA_W-1:0] REG_SW_BITS = 8'h0F;
   localparam logic [DATA_W-1:0] REG_LDO_BITS = 8'hF0;
   localparam int TOP_SYS = 3;
   localparam int TOP_CHG = 2;
   localparam int TOP_SW = 1;
   localparam int TOP_LDO = 0;
   localparam int SOFT_RST_BIT = 7;

   // bus addressing
   localparam logic [2:0] OWN_ADDR_HI = 3'h6;
   localparam logic [2:0] OWN_ADDR_LO = 3'h1;
   localparam logic [6:0] GCALL_ADDR = 7'h00;
   localparam logic [6:0] DEVID_ADDR = 7'h7C;
   localparam logic [DATA_W-1:0] GC_RESET_CMD = 8'h06;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ID_LAST = 2'h2;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RACK} pmi_state_e;
   typedef enum logic [1:0] {KIND_OWN, KIND_GC, KIND_ID} pmi_kind_e;

   // storage entries held in the register memory, by index
   function automatic logic pmi_idx_stored(input int i);
      return (i >= 8 && i <= 13) || (i >= 16 && i <= 23) || (i >= 33 && i <= 49) || (i == 63);
   endfunction

   function automatic logic pmi_addr_stored(input logic [PTR_W-1:0] a);
      return (a == A_LAST) || (a[6] == 1'b0 && a != 7'h3F && pmi_idx_stored(int'(a)));
   endfunction

   function automatic logic [IDX_W-1:0] pmi_mem_idx(input logic [PTR_W-1:0] a);
      return (a == A_LAST) ? RESTART_IDX : a[IDX_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] pmi_mem_rst(input int i);
      case (i)
         9: return 8'h41;
         10: return 8'h89;
         11: return 8'hCE;
         12: return 8'h01;
         16: return 8'h03;
         17: return 8'h08;
         18: return 8'h04;
         19: return 8'h08;
         20: return 8'h04;
         21: return 8'h1E;
         22: return 8'h95;
         23: return 8'h24;
         34: return 8'h14;
         35: return 8'h0C;
         36, 40, 44, 48: return 8'h4F;
         37: return 8'h39;
         38, 42, 46: return 8'h1C;
         39, 43, 47: return 8'h4C;
         41, 45, 49: return 8'h0C;
         63: return 8'h80;
         default: return 8'h00;
      endcase
   endfunction
endpackage

// file: design/pmi_sync.sv
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/100ps
module pmi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r, agree;

   // first stage feeds only the second
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit moves only once stages two and three agree; one process keeps one driver
   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) q_r <= RST;
      else q_r <= (s3_r & agree) | (q_r & ~agree);
   end

   assign q = q_r;
endmodule // pmi_sync

// file: design/pmi_regmem.sv
// storage for the plain read-write control words, registered read port
`timescale 1ns/100ps
module pmi_regmem
   import pmi_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic soft_rst,
   input wire logic we,
   input wire logic [pmi_pkg::IDX_W-1:0] waddr,
   input wire logic [pmi_pkg::DATA_W-1:0] wdata,
   input wire logic [pmi_pkg::IDX_W-1:0] raddr,
   output logic [pmi_pkg::DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] rdata_r;

   // only mapped entries get flops; holes read as zero
   for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_ent
      if (pmi_idx_stored(i)) begin : g_st
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) mem[i] <= pmi_mem_rst(i);
            else if (soft_rst) mem[i] <= pmi_mem_rst(i);
            else if (we && waddr == IDX_W'(i)) mem[i] <= wdata;
         end
      end else begin : g_hole
         assign mem[i] = '0;
      end
   end

   // one cycle read latency, far below one bus bit time
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) rdata_r <= '0;
      else rdata_r <= mem[raddr];
   end

   assign rdata = rdata_r;
endmodule // pmi_regmem

// file: design/pmi_i2c_target.sv
// i2c target front end and register file of the power-management device
// Operation
// - target handles fast-mode-plus transfers up to 1 Mbit/s.
// - serial clock is never held low; only 7-bit addressing is decoded.
// - general call answered by default; build option can switch it off.
// - register pointer advances after each data byte and wraps around.
// - own address is 1,1,0,option,0,0,1 then direction, 0 write 1 read.
// - address bit 3 comes from the one-time trim option, default 0.
// - general call and device identification addresses are decoded separately.
// - each address has read-write, read-only, write-only or write-to-clear access.
// - write-to-clear clears only flag bits written as 1.
// - top summary register is read only; writes change nothing.
// - three event flag registers reset to zero and are write-to-clear.
// - mask registers are read-write; first mask resets to 0x3F.
// - control word at 0D is write-only, resets zero, reads zero.
// - summary bit is 1 while any flag of its group is set.
// - interrupt output is low while any unmasked flag is latched.
// - writing soft reset bit restores all registers; bit reads back 0.
// - information register holds 5-bit part id and 3-bit revision.
`timescale 1ns/100ps
module pmi_i2c_target
   import pmi_pkg::*;
#(
   parameter bit GCALL_ENABLE = 1'b1,
   parameter logic [4:0] PART_ID = 5'h0A, // arbitrary value
   parameter logic [2:0] PART_REV = 3'h2, // arbitrary value
   parameter logic [23:0] ID_WORD = 24'h5A3C69 // arbitrary value
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic one_time_trim_option,
   input wire logic [pmi_pkg::DATA_W-1:0] sys_event_in,
   input wire logic [pmi_pkg::DATA_W-1:0] chg_event_in,
   input wire logic [pmi_pkg::DATA_W-1:0] reg_event_in,
   input wire logic [4*pmi_pkg::DATA_W-1:0] charger_state_in,
   input wire logic [pmi_pkg::DATA_W-1:0] regulator_state_in,
   output logic interrupt_out_n
);
   import pmi_pkg::*;

   localparam int EV_W = NGRP * DATA_W;
   localparam int SYNC_W = 3 + EV_W + 5 * DATA_W;
   localparam int S_REG_LSB = 4 * DATA_W;
   localparam int S_EV_LSB = 5 * DATA_W;
   localparam int S_SDA = S_EV_LSB + EV_W;
   localparam int S_SCL = S_SDA + 1;
   localparam int S_TRIM = S_SDA + 2;
   localparam int VD_MAX = VD_CYC;
   localparam logic [SYNC_W-1:0] SYNC_RST = {3'h3, {(SYNC_W - 3){1'b0}}};

   logic [SYNC_W-1:0] sync_in, sync_q;
   logic scl_q, sda_q, trim_q, scl_d_r, sda_d_r;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [EV_W-1:0] ev_q, ev_d_r, ev_rise;
   logic [4*DATA_W-1:0] chg_state_q;
   logic [DATA_W-1:0] reg_state_q;

   // all pins and analog-side levels cross through one synchroniser bank
   assign sync_in = {one_time_trim_option, scl_in, sda_in, reg_event_in, chg_event_in,
                     sys_event_in, regulator_state_in, charger_state_in};

   pmi_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .d(sync_in),
      .q(sync_q)
   );

   assign trim_q = sync_q[S_TRIM];
   assign scl_q = sync_q[S_SCL];
   assign sda_q = sync_q[S_SDA];
   assign ev_q = sync_q[S_EV_LSB +: EV_W];
   assign reg_state_q = sync_q[S_REG_LSB +: DATA_W];
   assign chg_state_q = sync_q[S_REG_LSB-1:0];

   // edge history of filtered levels
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         ev_d_r <= '0;
      end else begin
         scl_d_r <= scl_q;
         sda_d_r <= sda_q;
         ev_d_r <= ev_q;
      end
   end

   // bus conditions; sampling at 50 MHz leaves margin at 1 Mbit/s
   assign scl_rise = scl_q & ~scl_d_r;
   assign scl_fall = ~scl_q & scl_d_r;
   assign start_det = scl_q & scl_d_r & sda_d_r & ~sda_q;
   assign stop_det = scl_q & scl_d_r & ~sda_d_r & sda_q;
   assign ev_rise = ev_q & ~ev_d_r;

   pmi_state_e state_r;
   pmi_kind_e kind_r;
   logic [2:0] bit_cnt_r;
   logic [DATA_W-1:0] shift_r, tx_r, shift_nxt, wdata;
   logic sda_oe_n_r, ack_on_r, rd_r, ptr_pend_r, more_r;
   logic [1:0] id_cnt_r;
   logic [PTR_W-1:0] ptr_r, ptr_inc;
   logic byte_done, hit_own, hit_gc, hit_id, addr_ok;
   logic reg_wr, gc_rst, soft_rst, mem_we, ptr_load, adv, mask_any_wr;
   logic [6:0] own_addr;

   // address decode, 7-bit only, no extended addressing
   assign shift_nxt = {shift_r[DATA_W-2:0], sda_q};
   assign byte_done = scl_rise && bit_cnt_r == BIT_LAST;
   assign own_addr = {OWN_ADDR_HI, trim_q, OWN_ADDR_LO};
   assign hit_own = shift_nxt[7:1] == own_addr;
   assign hit_gc = GCALL_ENABLE && shift_nxt[7:1] == GCALL_ADDR && !shift_nxt[0];
   assign hit_id = shift_nxt[7:1] == DEVID_ADDR;
   assign addr_ok = hit_own | hit_gc | hit_id;

   // write side strobes
   assign wdata = shift_nxt;
   assign reg_wr = state_r == ST_WR && byte_done && kind_r == KIND_OWN && !ptr_pend_r;
   assign ptr_load = state_r == ST_WR && byte_done && kind_r == KIND_OWN && ptr_pend_r;
   assign gc_rst = state_r == ST_WR && byte_done && kind_r == KIND_GC && wdata == GC_RESET_CMD;
   assign soft_rst = (reg_wr && ptr_r == A_CTRL_E && wdata[SOFT_RST_BIT]) || gc_rst;
   assign mem_we = reg_wr && pmi_addr_stored(ptr_r) && !soft_rst;
   assign adv = reg_wr || (state_r == ST_RD && scl_fall && bit_cnt_r == BIT_LAST
                           && kind_r == KIND_OWN);
   assign ptr_inc = (ptr_r == A_LAST) ? A_FIRST : PTR_W'(ptr_r + 7'h01);

   // register pointer, kept across repeated start
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) ptr_r <= A_FIRST;
      else if (ptr_load) ptr_r <= wdata[PTR_W-1:0];
      else if (adv) ptr_r <= ptr_inc;
   end

   logic [DATA_W-1:0] flags_r [NGRP];
   logic [DATA_W-1:0] mask_r [NGRP];
   logic [DATA_W-1:0] flag_set [NGRP];
   logic [DATA_W-1:0] grp_rd [NGRP];
   logic [NGRP-1:0] pend, mask_wr, flag_wr;

   // per-group event flags and masks
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      assign flag_set[g] = ev_rise[g*DATA_W +: DATA_W] & FLAG_IMPL[g];
      assign flag_wr[g] = reg_wr && ptr_r == A_FLAG[g];
      assign mask_wr[g] = reg_wr && ptr_r == A_MASK[g] && !soft_rst;
      assign pend[g] = |(flags_r[g] & ~mask_r[g]);
      assign grp_rd[g] = (ptr_r == A_FLAG[g]) ? flags_r[g] :
                         (ptr_r == A_MASK[g]) ? mask_r[g] : '0;

      // new events win over a clear in the same cycle
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) flags_r[g] <= '0;
         else if (soft_rst) flags_r[g] <= '0;
         else flags_r[g] <= (flags_r[g] & ~(flag_wr[g] ? wdata : '0)) | flag_set[g];
      end

      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) mask_r[g] <= MASK_RST[g];
         else if (soft_rst) mask_r[g] <= MASK_RST[g];
         else if (mask_wr[g]) mask_r[g] <= wdata;
      end
   end

   assign mask_any_wr = |mask_wr;

   // level output: a latched flag cannot fire again until cleared
   logic int_n_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) int_n_r <= 1'b1;
      else int_n_r <= ~|pend;
   end

   logic [DATA_W-1:0] mem_rdata, top_sum, device_information, id_byte, rd_reg, load_byte;
   logic stat_hit, mem_hit;

   pmi_regmem u_mem (
      .clock(clock),
      .resetn(resetn),
      .soft_rst(soft_rst),
      .we(mem_we),
      .waddr(pmi_mem_idx(ptr_r)),
      .wdata(wdata),
      .raddr(pmi_mem_idx(ptr_r)),
      .rdata(mem_rdata)
   );

   // summary bits follow the flags directly, so they drop with the last clear
   assign top_sum[DATA_W-1:TOP_SYS+1] = '0;
   assign top_sum[TOP_SYS] = |flags_r[0];
   assign top_sum[TOP_CHG] = |flags_r[1];
   assign top_sum[TOP_SW] = |(flags_r[2] & REG_SW_BITS);
   assign top_sum[TOP_LDO] = |(flags_r[2] & REG_LDO_BITS);
   assign device_information = {PART_ID, PART_REV};
   assign id_byte = ID_WORD[(DATA_W * (2 - int'(id_cnt_r))) +: DATA_W];

   // read decode; write-only word and holes give zero
   assign stat_hit = ptr_r[PTR_W-1:2] == A_CHG_STATE_A[PTR_W-1:2];
   assign mem_hit = pmi_addr_stored(ptr_r) && ptr_r != A_CTRL_E;
   assign rd_reg = (ptr_r == A_DEVICE_INFORMATION) ? device_information :
                   (ptr_r == A_TOP_SUM) ? top_sum :
                   stat_hit ? chg_state_q[DATA_W*ptr_r[1:0] +: DATA_W] :
                   (ptr_r == A_REG_STATE) ? reg_state_q :
                   mem_hit ? mem_rdata :
                   (grp_rd[0] | grp_rd[1] | grp_rd[2]);
   assign load_byte = (kind_r == KIND_ID) ? id_byte : rd_reg;

   // bus state machine; data change right after scl falls, never holds scl
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         kind_r <= KIND_OWN;
         bit_cnt_r <= '0;
         shift_r <= '0;
         tx_r <= '0;
         sda_oe_n_r <= 1'b1;
         ack_on_r <= 1'b0;
         rd_r <= 1'b0;
         ptr_pend_r <= 1'b0;
         more_r <= 1'b0;
         id_cnt_r <= '0;
      end else if (start_det) begin
         state_r <= ST_ADDR;
         bit_cnt_r <= '0;
         sda_oe_n_r <= 1'b1;
         ack_on_r <= 1'b0;
         id_cnt_r <= '0;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         sda_oe_n_r <= 1'b1;
      end else begin
         case (state_r)
            ST_ADDR: if (scl_rise) begin
               shift_r <= shift_nxt;
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (byte_done && addr_ok) begin
                  state_r <= ST_ACK;
                  rd_r <= shift_nxt[0];
                  kind_r <= hit_gc ? KIND_GC : hit_id ? KIND_ID : KIND_OWN;
                  ptr_pend_r <= !shift_nxt[0];
               end else if (byte_done) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_ACK: if (scl_fall) begin
               bit_cnt_r <= '0;
               if (!ack_on_r) begin
                  sda_oe_n_r <= 1'b0;
                  ack_on_r <= 1'b1;
               end else if (rd_r) begin
                  ack_on_r <= 1'b0;
                  tx_r <= {load_byte[DATA_W-2:0], 1'b0};
                  sda_oe_n_r <= load_byte[DATA_W-1];
                  state_r <= ST_RD;
               end else begin
                  ack_on_r <= 1'b0;
                  sda_oe_n_r <= 1'b1;
                  state_r <= ST_WR;
               end
            end
            ST_WR: if (scl_rise) begin
               shift_r <= shift_nxt;
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (byte_done) begin
                  state_r <= ST_ACK;
                  ptr_pend_r <= 1'b0;
               end
            end
            ST_RD: if (scl_fall) begin
               if (bit_cnt_r == BIT_LAST) begin
                  sda_oe_n_r <= 1'b1;
                  state_r <= ST_RACK;
                  id_cnt_r <= (id_cnt_r == ID_LAST) ? 2'h0 : id_cnt_r + 2'h1;
               end else begin
                  sda_oe_n_r <= tx_r[DATA_W-1];
                  tx_r <= {tx_r[DATA_W-2:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
               end
            end
            ST_RACK: if (scl_rise) begin
               more_r <= !sda_q;
            end else if (scl_fall && more_r) begin
               bit_cnt_r <= '0;
               tx_r <= {load_byte[DATA_W-2:0], 1'b0};
               sda_oe_n_r <= load_byte[DATA_W-1];
               state_r <= ST_RD;
            end else if (scl_fall) begin
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // open drain: output level fixed low, only the enable moves
   logic sda_out_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) sda_out_r <= 1'b0;
      else sda_out_r <= 1'b0;
   end

   assign sda_out = sda_out_r;
   assign sda_oe_n = sda_oe_n_r;
   assign interrupt_out_n = int_n_r;

   // checks on the design's own behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_addr_nak: assert property (
      (state_r == ST_ADDR && byte_done && !addr_ok && !stop_det) |=>
         (state_r == ST_IDLE && sda_oe_n_r) [*2])
      else $error("unmatched address was acknowledged");

   a_gcall_option: assert property (
      (state_r == ST_ADDR && byte_done && shift_nxt == {GCALL_ADDR, 1'b0}) |=>
         ((state_r == ST_ACK) == GCALL_ENABLE))
      else $error("general call handling disagrees with build option");

   a_no_drive_addr: assert property (
      (state_r == ST_IDLE || state_r == ST_ADDR || state_r == ST_WR) |-> sda_oe_n_r)
      else $error("data line driven outside ack or read phase");

   a_ack_release: assert property (
      (state_r == ST_ACK && ack_on_r && !rd_r && scl_fall && !stop_det && !start_det) |->
         ##[1:VD_MAX] sda_oe_n_r)
      else $error("ack not released within data valid time");

   a_w1c_exact: assert property (
      (flag_wr[0] && !soft_rst) |=>
         ((flags_r[0] & $past(wdata)) == ($past(flag_set[0]) & $past(wdata)))
         && ((flags_r[0] & ~$past(wdata)) ==
             (($past(flags_r[0]) | $past(flag_set[0])) & ~$past(wdata))))
      else $error("write-to-clear touched wrong flag bits");

   a_sum_ro: assert property (
      (reg_wr && ptr_r == A_TOP_SUM && ev_rise == '0) |=>
         $stable(flags_r[0]) && $stable(flags_r[1]) && $stable(flags_r[2]))
      else $error("write to summary register changed flags");

   a_sum_tracks: assert property (
      (ptr_r == A_TOP_SUM) |-> (rd_reg[TOP_SYS] == (flags_r[0] != '0)
                                && rd_reg[TOP_CHG] == (flags_r[1] != '0)))
      else $error("summary bit does not follow its group");

   a_irq_cause: assert property (
      $fell(int_n_r) |-> ($past(|ev_rise, 2) || $past(mask_any_wr, 2)))
      else $error("interrupt asserted with no new event");

   a_wo_zero: assert property (
      (ptr_r == A_CTRL_E) |-> rd_reg == '0)
      else $error("write-only word returned data");

   a_soft_reset: assert property (
      soft_rst |=> (mask_r[0] == MASK_RST[0] && flags_r[1] == '0 && mask_r[2] == MASK_RST[2]))
      else $error("soft reset did not restore defaults");

   a_ptr_wrap: assert property (
      (adv && ptr_r == A_LAST) |=> ptr_r == A_FIRST)
      else $error("pointer failed to wrap to zero");

   a_hole_zero: assert property (
      (ptr_r > A_MODE_LAST && ptr_r < A_LAST) |-> rd_reg == '0)
      else $error("unmapped address read non-zero");
endmodule // pmi_i2c_target

// file: dv/pmi_host.sv
// i2c bus controller model that drives the target from the host side
`timescale 1ns/100ps
module pmi_host (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   localparam time Q = 200; // quarter bit, keeps each scl phase far above the sampling span
   logic [8:0] sh;
   // bus idle with both lines released; the clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // start or repeated start, leaves the clock low
   task automatic start();
      #Q sda_drv = 1'b1;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b0;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q sda_drv = 1'b0;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b1;
      #Q;
   endtask
   // eight bits msb first plus the ninth; a released line reads the pull-up level
   task automatic xfer(input logic [7:0] tx, input logic ak_tx, output logic [7:0] rx,
      output logic ak_rx);
      for (int i = 8; i >= 0; i--) begin
         #Q sda_drv = (i > 0) ? tx[i-1] : ak_tx;
         #Q scl = 1'b1;
         #Q sh = {sh[7:0], sda};
         #Q scl = 1'b0;
      end
      rx = sh[8:1];
      ak_rx = sh[0];
   endtask
endmodule // pmi_host

// file: dv/test_pmi_i2c_target.sv
// self-checking bench for the power-management i2c target and its register file
`timescale 1ns/100ps
module test_pmi_i2c_target;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic trim = 1'b0;
   logic [7:0] sys_ev = 8'h00;
   logic [7:0] chg_ev = 8'h00;
   logic [7:0] reg_ev = 8'h00;
   logic scl, sda_drv, sda_out, sda_oe_n, int_n, ak;
   logic [7:0] own = 8'hC2;
   logic [7:0] rx;
   int err_count = 0;
   int checked = 0;
   wire sda = sda_drv & (sda_oe_n | sda_out); // open drain with pull-up
   always #10 clock = ~clock;
   pmi_i2c_target u_pmi_i2c_target (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .one_time_trim_option(trim), .sys_event_in(sys_ev),
      .chg_event_in(chg_ev), .reg_event_in(reg_ev), .charger_state_in(32'h12345678),
      .regulator_state_in(8'hA5), .interrupt_out_n(int_n));
   pmi_host u_pmi_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic acked);
      u_pmi_host.xfer(b, 1'b1, rx, ak);
      chk("ack", {7'h00, ~acked}, {7'h00, ak});
   endtask
   task automatic probe(input logic [7:0] b, input logic acked);
      u_pmi_host.start();
      send(b, acked);
      u_pmi_host.stop();
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_pmi_host.start();
      send(own, 1'b1);
      send(p, 1'b1);
      send(d, 1'b1);
      u_pmi_host.stop();
   endtask
   // start, read address byte, then a burst read nacked on its last byte
   task automatic rd_at(input logic [7:0] a, input logic [7:0] e[$]);
      u_pmi_host.start();
      send(a, 1'b1);
      foreach (e[i]) begin
         u_pmi_host.xfer(8'hFF, i == e.size() - 1, rx, ak);
         chk("read", e[i], rx);
      end
      u_pmi_host.stop();
   endtask
   // pointer write, then a repeated start into the burst read
   task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
      u_pmi_host.start();
      send(own, 1'b1);
      send(p, 1'b1);
      rd_at(own | 8'h01, e);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog, well beyond the roughly one millisecond the sequence needs
   initial begin
      #1_800_000;
      err_count++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end
   // info word is the default part id and revision, 8'h52
   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock) resetn = 1'b1;
      repeat (10) @(negedge clock);
      rd(8'h00, {8'h52, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h7F, 8'h00, 8'hFF, 8'h00, 8'h41, 8'h89,
         8'hCE, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03});
      rd(8'h18, {8'h78, 8'h56, 8'h34, 8'h12});
      rd(8'h1F, {8'h00, 8'hA5});
      wr(8'h00, 8'hFF);
      wr(8'h01, 8'hFF);
      wr(8'h03, 8'h12);
      rd(8'h00, {8'h52, 8'h00, 8'h00, 8'h12});
      @(negedge clock) sys_ev = 8'h09;
      repeat (10) @(negedge clock);
      chk("int", 8'h00, {7'h00, int_n});
      rd(8'h01, {8'h08, 8'h09});
      wr(8'h02, 8'h08);
      rd(8'h01, {8'h08, 8'h01});
      chk("int", 8'h00, {7'h00, int_n});
      wr(8'h02, 8'h01);
      rd(8'h01, {8'h00, 8'h00});
      chk("int", 8'h01, {7'h00, int_n});
      // events drop again before the soft reset so no fresh edge follows it
      @(negedge clock) chg_ev = 8'h80;
      reg_ev = 8'h11;
      repeat (10) @(negedge clock);
      sys_ev = 8'h00;
      chg_ev = 8'h00;
      reg_ev = 8'h00;
      rd(8'h01, {8'h07, 8'h00, 8'h12, 8'h80, 8'h7F, 8'h11});
      chk("int", 8'h00, {7'h00, int_n});
      wr(8'h71, 8'h55);
      rd(8'h71, {8'h55, 8'h52});
      wr(8'h0D, 8'h80);
      rd(8'h70, {8'h00, 8'h80});
      rd(8'h01, {8'h00, 8'h00, 8'h3F, 8'h00});
      chk("int", 8'h01, {7'h00, int_n});
      rd(8'h0D, {8'h00});
      probe(8'h00, 1'b1);
      probe(8'hF8, 1'b1);
      probe(8'hF0, 1'b0);
      probe(8'hD2, 1'b0);
      @(negedge clock) trim = 1'b1;
      own = 8'hD2;
      repeat (10) @(negedge clock);
      probe(8'hC2, 1'b0);
      wr(8'h03, 8'h12);
      // general call reset command brings the mask back to its default
      u_pmi_host.start();
      send(8'h00, 1'b1);
      send(8'h06, 1'b1);
      u_pmi_host.stop();
      rd(8'h03, {8'h3F});
      // identification address returns the id word high byte first, then repeats
      rd_at(8'hF9, {8'h5A, 8'h3C, 8'h69, 8'h5A});
      results();
   end
endmodule // test_pmi_i2c_target
